// >>> hw/pwm_gen_pkg.sv
// package: register map, field layout and encodings of the pwm generator
package pwm_gen_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          CNT_W           = 16;
    localparam logic [3:0]  OFF_CONTROL     = 4'h0;
    localparam logic [3:0]  OFF_PHASE       = 4'h4;
    localparam logic [3:0]  OFF_DUTY        = 4'h8;
    localparam logic [3:0]  OFF_DEAD        = 4'hC;
    localparam int          CTL_IUE_BIT     = 0;
    localparam int          CTL_XPR_BIT     = 1;
    localparam int          CTL_CAM_BIT     = 2;
    localparam int          CTL_MTB_BIT     = 3;
    localparam int          CTL_DTC_LSB     = 6;
    localparam int          CTL_ITB_BIT     = 9;
    localparam int          CTL_IOM_LSB     = 10;
    localparam int          CTL_CLM_BIT     = 12;
    localparam logic [15:0] CTL_WR_MASK     = 16'h1FCF;
    localparam logic [15:0] CONTROL_RST     = 16'h0000;
    localparam logic [15:0] PHASE_RST       = 16'h0000;
    localparam logic [15:0] DUTY_RST        = 16'h0000;
    localparam logic [15:0] DEAD_RST        = 16'h0000;
    localparam logic [15:0] CA_RES_MASK     = 16'hFFF8;
    localparam logic [1:0]  DTC_POSITIVE    = 2'h0;
    localparam logic [1:0]  DTC_NEGATIVE    = 2'h1;
    localparam logic [1:0]  DTC_DISABLED    = 2'h2;
    localparam logic [1:0]  IOM_TRUE_INDEP  = 2'h3;

    typedef struct packed {
        logic [15:0] duty;
        logic [15:0] phase;
        logic [15:0] dead;
    } timing_s;

    typedef enum logic [1:0] {
        CNT_UP   = 2'b01,
        CNT_DOWN = 2'b10
    } dir_e;
endpackage

// >>> hw/pwm_time_base.sv
// local time base counter: edge aligned sawtooth or center aligned triangle
`timescale 1ns/1ps
module pwm_time_base (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      center_i,
    input  wire logic                      restart_i,
    input  wire logic [15:0]               period_i,
    output logic      [15:0]               count_o,
    output logic                           boundary_o
);
    import pwm_gen_pkg::*;

    pwm_gen_pkg::dir_e dir_ff;
    pwm_gen_pkg::dir_e nxt_dir;
    logic [15:0]       count_ff;
    logic [15:0]       nxt_count;
    wire               at_top  = (count_ff >= period_i);
    wire               at_zero = (count_ff == 16'h0000);

    // boundary marks the last cycle of a period; the new period starts in the next cycle
    assign boundary_o = center_i ? (dir_ff == CNT_DOWN && at_zero) || (dir_ff == CNT_UP && period_i == 16'h0000)
                                 : at_top;
    assign count_o    = count_ff;

    always_comb begin
        nxt_count = count_ff;
        nxt_dir   = dir_ff;
        unique case (dir_ff)
            CNT_UP: begin
                if (at_top) begin
                    nxt_count = center_i ? period_i - 16'h0001 : 16'h0000;
                    nxt_dir   = center_i ? CNT_DOWN : CNT_UP;
                end else begin
                    nxt_count = count_ff + 16'h0001;
                end
            end
            CNT_DOWN: begin
                if (at_zero || !center_i) begin
                    nxt_count = at_zero ? 16'h0001 : 16'h0000;
                    nxt_dir   = CNT_UP;
                end else begin
                    nxt_count = count_ff - 16'h0001;
                end
            end
        endcase
        if (restart_i) begin
            nxt_count = 16'h0000;
            nxt_dir   = CNT_UP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= 16'h0000;
            dir_ff   <= CNT_UP;
        end else begin
            count_ff <= nxt_count;
            dir_ff   <= nxt_dir;
        end
    end
endmodule

// >>> hw/pwm_generator_phase_control.sv
// pwm generator: control and phase registers over wishbone, time base, outputs
// Operation
// - dead-time field: 00 positive, 01 negative complementary, 10 off, 11 reserved.
// - time-base select 1 uses secondary master base if present, else primary.
// - center-align enable 1 gives center-aligned counting, 0 edge-aligned.
// - center-align bit ignored unless the independent time base is enabled.
// - center-aligned mode drops three low bits of duty, phase, dead time.
// - external period reset with independent base lets current limit restart base.
// - immediate update off: timing values load at local period boundary.
// - no independent base, paired modes: phase shifts both outputs.
// - no independent base, true independent: phase shifts high output only.
// - independent base, paired modes: phase is local period of both outputs.
// - independent base, true independent: phase is local period of high only; the low output here runs from the same local base.
// - phase register is 16-bit read/write, resets to zero.
// - control bits 5 and 4 always read zero.
`timescale 1ns/1ps
module pwm_generator_phase_control (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [pwm_gen_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [31:0]               dat_i,
    output logic      [31:0]               dat_o,
    output logic                           ack_o,
    input  wire logic                      primary_sync_i,
    input  wire logic                      secondary_sync_i,
    input  wire logic                      secondary_present_i,
    input  wire logic [15:0]               master_period_i,
    input  wire logic                      current_limit_i,
    output logic                           gen_high_output_o,
    output logic                           gen_low_output_o
);
    import pwm_gen_pkg::*;

    // pin inputs pass two flip-flops before use
    logic [1:0]  prim_sync_ff;
    logic [1:0]  sec_sync_ff;
    logic [1:0]  climit_ff;
    logic        climit_last_ff;

    logic [15:0] control_ff;
    timing_s     pend_ff;
    timing_s     act_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        high_ff;
    logic        low_ff;
    logic        master_last_ff;
    logic [15:0] master_cnt_ff;

    // field decode
    wire         immediate_update_en      = control_ff[CTL_IUE_BIT];
    wire         ext_period_reset_en    = control_ff[CTL_XPR_BIT];
    wire         center_align_en      = control_ff[CTL_CAM_BIT];
    wire         time_base_select     = control_ff[CTL_MTB_BIT];
    wire  [1:0]  dead_time_ctrl      = control_ff[CTL_DTC_LSB +: 2];
    wire         independent_base_en      = control_ff[CTL_ITB_BIT];
    wire  [1:0]  io_mode  = control_ff[CTL_IOM_LSB +: 2];
    wire         true_ind = (io_mode == IOM_TRUE_INDEP);

    wire         center   = center_align_en && independent_base_en;

    function automatic logic [15:0] ca_trim(input logic [15:0] v, input logic ca);
        ca_trim = ca ? (v & CA_RES_MASK) : v;
    endfunction

    function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] d,
                                                input logic [3:0] sel);
        merge_lanes = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // bus decode
    wire         req       = cyc_i && stb_i && !ack_ff;
    wire         wr        = req && we_i;
    wire         hit_ctl   = (adr_i == OFF_CONTROL);
    wire         hit_phase = (adr_i == OFF_PHASE);
    wire         hit_duty  = (adr_i == OFF_DUTY);
    wire         hit_dead  = (adr_i == OFF_DEAD);

    wire  [15:0] nxt_control = merge_lanes(control_ff, dat_i, sel_i) & CTL_WR_MASK;
    timing_s     nxt_pend;
    assign nxt_pend.phase = (wr && hit_phase) ? merge_lanes(pend_ff.phase, dat_i, sel_i) : pend_ff.phase;
    assign nxt_pend.duty  = (wr && hit_duty)  ? merge_lanes(pend_ff.duty,  dat_i, sel_i) : pend_ff.duty;
    assign nxt_pend.dead  = (wr && hit_dead)  ? merge_lanes(pend_ff.dead,  dat_i, sel_i) : pend_ff.dead;

    wire  [15:0] rd_mux = hit_ctl   ? control_ff :
                          hit_phase ? pend_ff.phase :
                          hit_duty  ? pend_ff.duty :
                          hit_dead  ? pend_ff.dead : 16'h0000;

    // master sync source choice
    wire         use_sec    = time_base_select && secondary_present_i;
    wire         master_evt = use_sec ? sec_sync_ff[1] : prim_sync_ff[1];
    wire         master_rise = master_evt && !master_last_ff;

    // current limit rising edge restarts the local base only when enabled
    wire         climit_rise = climit_ff[1] && !climit_last_ff;
    wire         ext_reset   = ext_period_reset_en && independent_base_en && climit_rise;

    // local period: phase register when independent, else master period
    wire  [15:0] local_period = independent_base_en ? ca_trim(act_ff.phase, center) : master_period_i;
    wire  [15:0] tb_count;
    wire         tb_boundary;

    pwm_time_base u_time_base (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .center_i   (center),
        .restart_i  (ext_reset || (!independent_base_en && master_rise)),
        .period_i   (local_period),
        .count_o    (tb_count),
        .boundary_o (tb_boundary)
    );

    // phase shifted count against the master base when not independent
    // sum kept at 17 bits so a large phase cannot wrap and defeat the modulo test
    wire  [15:0] shifted = (({1'b0, master_cnt_ff} + {1'b0, act_ff.phase}) >= ({1'b0, master_period_i} + 17'h00001))
                           ? 16'(master_cnt_ff + act_ff.phase - master_period_i - 16'h0001)
                           : 16'(master_cnt_ff + act_ff.phase);
    wire  [15:0] cnt_high = independent_base_en ? tb_count : shifted;
    // true independent without the independent base: low output keeps the unshifted master count
    wire  [15:0] cnt_low  = (!independent_base_en && true_ind) ? master_cnt_ff : cnt_high;

    wire  [15:0] duty_eff = ca_trim(act_ff.duty, center);
    wire  [15:0] dead_eff = ca_trim(act_ff.dead, center);
    wire         raw_high = cnt_high < duty_eff;
    wire         raw_low_src = cnt_low < duty_eff;

    // dead time applied after count zero and, in paired modes, around the duty edge
    wire  [16:0] hi_start = {1'b0, dead_eff};
    wire  [16:0] lo_end   = {1'b0, duty_eff} + {1'b0, dead_eff};
    logic        nxt_high;
    logic        nxt_low;
    always_comb begin
        nxt_high = raw_high;
        nxt_low  = true_ind ? raw_low_src : !raw_high;
        if (!true_ind) begin
            unique case (dead_time_ctrl)
                DTC_POSITIVE: begin
                    nxt_high = raw_high && ({1'b0, cnt_high} >= hi_start);
                    nxt_low  = {1'b0, cnt_high} >= lo_end;
                end
                DTC_NEGATIVE: begin
                    nxt_high = raw_high || ({1'b0, cnt_high} < lo_end && cnt_high >= duty_eff);
                    nxt_low  = !raw_high || ({1'b0, cnt_high} < hi_start);
                end
                DTC_DISABLED: begin
                    nxt_high = raw_high;
                    nxt_low  = !raw_high;
                end
                default: begin
                    nxt_high = raw_high;
                    nxt_low  = !raw_high;
                end
            endcase
        end else if (dead_time_ctrl == DTC_POSITIVE) begin
            nxt_high = raw_high && ({1'b0, cnt_high} >= hi_start);
            nxt_low  = raw_low_src && ({1'b0, cnt_low} >= hi_start);
        end
    end

    assign ack_o             = ack_ff;
    assign dat_o             = rdata_ff;
    assign gen_high_output_o = high_ff;
    assign gen_low_output_o  = low_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prim_sync_ff   <= 2'h0;
            sec_sync_ff    <= 2'h0;
            climit_ff      <= 2'h0;
            climit_last_ff <= 1'b0;
            master_last_ff <= 1'b0;
        end else begin
            prim_sync_ff   <= {prim_sync_ff[0], primary_sync_i};
            sec_sync_ff    <= {sec_sync_ff[0], secondary_sync_i};
            climit_ff      <= {climit_ff[0], current_limit_i};
            climit_last_ff <= climit_ff[1];
            master_last_ff <= master_evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= req;
            rdata_ff <= (req && !we_i) ? {16'h0000, rd_mux} : rdata_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_ff <= CONTROL_RST;
        end else if (wr && hit_ctl) begin
            control_ff <= nxt_control;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_ff <= '{duty: DUTY_RST, phase: PHASE_RST, dead: DEAD_RST};
            act_ff  <= '{duty: DUTY_RST, phase: PHASE_RST, dead: DEAD_RST};
        end else begin
            pend_ff <= nxt_pend;
            if (immediate_update_en) begin
                act_ff <= nxt_pend;
            end else if (tb_boundary) begin
                act_ff <= pend_ff;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_cnt_ff <= 16'h0000;
        end else if (master_rise || master_cnt_ff >= master_period_i) begin
            master_cnt_ff <= 16'h0000;
        end else begin
            master_cnt_ff <= master_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_ff <= 1'b0;
            low_ff  <= 1'b0;
        end else begin
            high_ff <= nxt_high;
            low_ff  <= nxt_low;
        end
    end
endmodule

// >>> sim/pwm_gen_asserts.sv
// checker: bus handshake, register readback and paired output relations of the pwm generator
`timescale 1ns/1ps
module pwm_gen_asserts
    import pwm_gen_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    input  wire logic [31:0]       dat_o,
    input  wire logic              ack_o,
    input  wire logic              gen_high_output_o,
    input  wire logic              gen_low_output_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] ctl_ff;
    logic [15:0] phase_ff;
    logic [3:0]  settle_ff;
    wire logic [15:0] lane_m = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire logic        wr_ctl = ack_o && we_i && adr_i == OFF_CONTROL;
    wire logic        rd_ack = ack_o && !we_i;
    wire logic        mapped = adr_i == OFF_CONTROL || adr_i == OFF_PHASE || adr_i == OFF_DUTY || adr_i == OFF_DEAD;
    wire logic        compl  = ctl_ff[CTL_IOM_LSB +: 2] == 2'h0 && settle_ff == 4'hF;
    wire logic [1:0]  dead_time_ctrl    = ctl_ff[CTL_DTC_LSB +: 2];
    // settle hides the few cycles the registered outputs lag a mode change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_ff <= CONTROL_RST;
            phase_ff <= PHASE_RST;
            settle_ff <= 4'h0;
        end else begin
            if (wr_ctl) ctl_ff <= (ctl_ff & ~lane_m) | (dat_i[15:0] & lane_m & CTL_WR_MASK);
            if (ack_o && we_i && adr_i == OFF_PHASE) phase_ff <= (phase_ff & ~lane_m) | (dat_i[15:0] & lane_m);
            settle_ff <= wr_ctl ? 4'h0 : settle_ff + {3'h0, settle_ff != 4'hF};
        end
    end
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_pulse; ack_o ##1 !ack_o; endsequence
    a_ack_pulse:      assert property (s_req |=> s_pulse) else $error("ack not a single cycle pulse");
    a_no_stray_ack:   assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    a_ctl_readback:   assert property (rd_ack && adr_i == OFF_CONTROL |-> dat_o == {16'h0000, ctl_ff})
        else $error("control readback differs");
    a_phase_readback: assert property (rd_ack && adr_i == OFF_PHASE |-> dat_o == {16'h0000, phase_ff})
        else $error("phase readback differs");
    a_unmapped_zero:  assert property (rd_ack && !mapped |-> dat_o == 32'h0) else $error("unmapped read not zero");
    a_read_hold:      assert property ($changed(dat_o) |-> $rose(ack_o) && !we_i) else $error("read data moved");
    a_no_overlap:     assert property (compl && dead_time_ctrl == DTC_POSITIVE |-> !(gen_high_output_o && gen_low_output_o))
        else $error("outputs overlap with positive dead time");
    a_no_dead_gap:    assert property (compl && dead_time_ctrl == DTC_DISABLED |-> gen_high_output_o != gen_low_output_o)
        else $error("outputs not complementary with dead time off");
endmodule
bind pwm_generator_phase_control pwm_gen_asserts i_pwm_gen_asserts (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .gen_high_output_o(gen_high_output_o), .gen_low_output_o(gen_low_output_o));

// >>> sim/power_stage_model.sv
// power stage model: counts shoot-through and dead cycles and times the high side period
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic        clk_i,
    input  wire logic        clear_i,
    input  wire logic        high_i,
    input  wire logic        low_i,
    output logic      [15:0] both_high_o,
    output logic      [15:0] both_low_o,
    output logic      [15:0] rise_gap_o
);
    logic [15:0] now_ff;
    logic [15:0] last_rise_ff;
    logic        prev_high_ff;
    // a bridge leg must never see both switches on; the count shows how often it would
    always_ff @(posedge clk_i) begin
        prev_high_ff <= high_i;
        now_ff <= clear_i ? 16'h0000 : now_ff + 16'h0001;
        both_high_o <= clear_i ? 16'h0000 : both_high_o + {15'h0, high_i && low_i};
        both_low_o <= clear_i ? 16'h0000 : both_low_o + {15'h0, !high_i && !low_i};
        if (clear_i) begin
            last_rise_ff <= 16'h0000;
            rise_gap_o <= 16'h0000;
        end else if (high_i && !prev_high_ff) begin
            rise_gap_o <= now_ff - last_rise_ff;
            last_rise_ff <= now_ff;
        end
    end
endmodule

// >>> sim/tb.sv
// testbench: register rows, time base period, centre mode, dead-time codes and period reset
`timescale 1ns/1ps
module tb;
    import pwm_gen_pkg::*;
    typedef struct packed {
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [15:0] wd;
        logic [15:0] exp;
    } row_s;
    // independent base, immediate update, current limit mode left clear
    localparam logic [15:0] RUN_CTL = 16'h0201;
    localparam logic [1:0]  EXP_DT [4] = '{2'b01, 2'b10, 2'b00, 2'b00};
    localparam row_s ROWS [11] = '{
        '{1'b1, OFF_CONTROL, 4'h3, 16'hFFFF, 16'h0000}, '{1'b0, OFF_CONTROL, 4'h3, 16'h0000, 16'hFFFF & CTL_WR_MASK},
        '{1'b1, OFF_CONTROL, 4'h1, 16'h0000, 16'h0000}, '{1'b0, OFF_CONTROL, 4'h3, 16'h0000, 16'hFF00 & CTL_WR_MASK},
        '{1'b1, OFF_PHASE, 4'h3, 16'h1234, 16'h0000}, '{1'b0, OFF_PHASE, 4'h3, 16'h0000, 16'h1234},
        '{1'b1, OFF_PHASE, 4'h2, 16'hAB00, 16'h0000}, '{1'b0, OFF_PHASE, 4'h3, 16'h0000, 16'hAB34},
        '{1'b1, 4'h2, 4'h3, 16'hFFFF, 16'h0000}, '{1'b0, 4'h2, 4'h3, 16'h0000, 16'h0000},
        '{1'b0, 4'h6, 4'h3, 16'h0000, 16'h0000}};
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, current_limit_i, clear, high, low;
    logic [3:0]  adr_i, sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] both_high, both_low, gap, g1, g2, g3;
    int          mismatches, checks_done;
    pwm_generator_phase_control i_pwm_generator_phase_control (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .primary_sync_i(1'b0), .secondary_sync_i(1'b0), .secondary_present_i(1'b0), .master_period_i(16'h0100),
        .current_limit_i(current_limit_i), .gen_high_output_o(high), .gen_low_output_o(low));
    power_stage_model i_power_stage_model (.clk_i(clk_i), .clear_i(clear), .high_i(high), .low_i(low),
        .both_high_o(both_high), .both_low_o(both_low), .rise_gap_o(gap));
    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [15:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {16'h0000, d};
        // look at ack mid-cycle so it is settled; the request stays up through the next rising edge
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
        r = dat_o;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] junk;
        bus(1'b1, a, 4'h3, d, junk);
    endtask
    // n slots of 48 cycles; with pulse set each slot opens with a current limit event
    task automatic measure(input int n, input logic pulse, output logic [15:0] g);
        @(posedge clk_i);
        clear <= 1'b1;
        @(posedge clk_i);
        clear <= 1'b0;
        repeat (n) begin
            current_limit_i <= pulse;
            repeat (2) @(posedge clk_i);
            current_limit_i <= 1'b0;
            repeat (46) @(posedge clk_i);
        end
        g = gap;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        mismatches = 0;
        checks_done = 0;
        {rst_i, clear, cyc_i, stb_i, we_i, current_limit_i} = 6'b110000;
        {adr_i, sel_i, dat_i} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        clear <= 1'b0;
        foreach (ROWS[i]) begin
            bus(ROWS[i].we, ROWS[i].adr, ROWS[i].sel, ROWS[i].wd, rd);
            if (!ROWS[i].we) check(rd, {16'h0000, ROWS[i].exp});
        end
        // no status flag here for software to clear phase-shift range only matters without itb
        wr(OFF_PHASE, 16'h0040);
        wr(OFF_DUTY, 16'h0020);
        wr(OFF_DEAD, 16'h0008);
        for (int d = 0; d < 4; d++) begin
            wr(OFF_CONTROL, RUN_CTL | (16'(d) << CTL_DTC_LSB));
            measure(7, 1'b0, g1);
            check({30'h0, both_high != 16'h0, both_low != 16'h0}, {30'h0, EXP_DT[d]});
        end
        measure(11, 1'b0, g1);
        wr(OFF_PHASE, 16'h0080);
        measure(11, 1'b0, g2);
        check({16'h0, g2 - g1}, 32'h0000_0040);
        // dead time off in centre mode: one high pulse per triangle, so the rise gap is the full period
        wr(OFF_CONTROL, RUN_CTL | 16'h0084);
        measure(17, 1'b0, g3);
        check({31'h0, g3 >= 16'h00FE && g3 <= 16'h0102}, 32'h1);
        wr(OFF_PHASE, 16'h0084);
        measure(17, 1'b0, g1);
        check({16'h0, g1}, {16'h0, g3});
        wr(OFF_CONTROL, RUN_CTL | 16'h0002);
        measure(8, 1'b1, g1);
        check({16'h0, g1}, 32'h0000_0030);
        wr(OFF_CONTROL, RUN_CTL);
        measure(10, 1'b1, g1);
        check({16'h0, g1}, {16'h0, g2 + 16'h0004});
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, OFF_CONTROL, 4'h3, 16'h0, rd);
        check(rd, {16'h0, CONTROL_RST});
        bus(1'b0, OFF_PHASE, 4'h3, 16'h0, rd);
        check(rd, 32'h0);
        end_of_test();
    end
endmodule
